//--- verilog/flash_host_map.svh
// Offsets, field positions, command codes and timing counts of the flash status controller.
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RDATA 8'h10
`define CTRL_CMD_MSB 2
`define CTRL_CMD_LSB 0
`define CTRL_ABORT_BIT 3
`define ST_BUSY_BIT 0
`define ST_OK_BIT 1
`define ST_FAIL_BIT 2
`define ST_CLOSED_BIT 3
`define ST_REJECTED_BIT 4
`define RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Command codes written to the control register
// ----------------------------------------------------------------
`define CMD_READ 3'h1
`define CMD_WRITE 3'h2
`define CMD_POLL 3'h3
`define CMD_RESET 3'h4
`define CMD_ERASE_ADD 3'h5

// ----------------------------------------------------------------
// Flash data bytes and bit positions
// ----------------------------------------------------------------
`define BYTE_RESET 8'hf0
`define BYTE_SECTOR_ERASE 8'h30
`define BIT_TOGGLE 6
`define BIT_FAIL 5
`define BIT_WINDOW 3
`define FL_ADDR_W 17

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS 4
`define T_ACC_NS 120
`define T_WP_NS 50
`define T_REC_NS 20
`define SYNC_CYC 2
`define RD_CYC (8'((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS) + 8'(`SYNC_CYC))
`define WP_CYC (8'((`T_WP_NS + `CLK_NS - 1) / `CLK_NS))
`define REC_CYC (8'((`T_REC_NS + `CLK_NS - 1) / `CLK_NS))

`endif

//--- verilog/flash_host_pkg.sv
// Types shared by the flash status controller and its bus cycle engine.
`default_nettype none
`include "flash_host_map.svh"

package flash_host_pkg;

	typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} cyc_phase_t;

	typedef struct packed {
		cyc_phase_t phase;
		logic [7:0] cnt;
		logic wr;
		logic [`FL_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic dq_oe_n;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] rdata;
		logic done;
	} cyc_state_t;

	typedef enum logic [3:0] {
		H_IDLE, H_READ, H_WRITE, H_POLL_FIRST, H_POLL_SECOND, H_RESET, H_ERASE_PRE, H_ERASE_WR, H_ERASE_POST
	} host_phase_t;

	typedef struct packed {
		host_phase_t phase;
		logic recheck;
		logic abort_req;
		logic [7:0] first;
		logic [7:0] rdata;
		logic [`FL_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic ok;
		logic fail;
		logic closed;
		logic rejected;
		logic cy_start;
		logic cy_wr;
		logic [`FL_ADDR_W-1:0] cy_addr;
		logic [7:0] cy_data;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} host_state_t;

endpackage

`default_nettype wire

//--- verilog/flash_cycle.sv
// Single asynchronous read or write bus cycle on the flash pins.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module flash_cycle import flash_host_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request from the controller
	input wire logic start,
	input wire logic wr,
	input wire logic [`FL_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic [7:0] rdata,
	// Flash pins
	output logic [`FL_ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_dq_out,
	input wire logic [7:0] fl_dq_in,
	output logic fl_dq_oe_n,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n
);

	localparam cyc_state_t CYC_RESET = '{phase: CY_IDLE, cnt: 8'h00, wr: 1'b0, addr: '0, wdata: 8'h00,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, sync1: 8'h00, sync2: 8'h00, rdata: 8'h00, done: 1'b0};

	cyc_state_t s_reg;
	cyc_state_t s_next;

	// ----------------------------------------------------------------
	// Cycle sequencing
	// ----------------------------------------------------------------
	// The access phase includes the synchroniser latency, so the byte taken
	// at its end was on the pins well inside the enabled window.
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.sync1 = fl_dq_in;
		s_next.sync2 = s_reg.sync1;
		unique case (s_reg.phase)
			CY_IDLE: begin
				if (start) begin
					s_next.phase = CY_ACT;
					s_next.wr = wr;
					s_next.addr = addr;
					s_next.wdata = wdata;
					s_next.ce_n = 1'b0; // [R21]
					s_next.oe_n = wr; // [R21]
					s_next.we_n = ~wr;
					s_next.dq_oe_n = ~wr;
					s_next.cnt = wr ? `WP_CYC : `RD_CYC;
				end
			end
			CY_ACT: begin
				if (s_reg.cnt > 8'h01) begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end else begin
					if (!s_reg.wr) begin
						s_next.rdata = s_reg.sync2; // [R21]
					end
					s_next.ce_n = 1'b1;
					s_next.oe_n = 1'b1;
					s_next.we_n = 1'b1;
					s_next.phase = CY_REC;
					s_next.cnt = `REC_CYC;
				end
			end
			CY_REC: begin
				// Chip enable stays high here, so every status read is a distinct cycle.
				if (s_reg.cnt > 8'h01) begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end else begin
					s_next.phase = CY_IDLE;
					s_next.dq_oe_n = 1'b1;
					s_next.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= CYC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done = s_reg.done;
	assign rdata = s_reg.rdata;
	assign fl_addr = s_reg.addr;
	assign fl_dq_out = s_reg.wdata;
	assign fl_dq_oe_n = s_reg.dq_oe_n;
	assign fl_ce_n = s_reg.ce_n;
	assign fl_oe_n = s_reg.oe_n;
	assign fl_we_n = s_reg.we_n;

endmodule

`default_nettype wire

//--- verilog/flash_host.sv
// APB-controlled host that runs status polling and erase-window checks on a parallel flash.
// ----------------------------------------------------------------
// How it works
// [R1] Read byte twice, compare toggle bit.
// [R2] Device stops toggling when done; data valid.
// [R3] Still toggling: check fail flag, then retest.
// [R4] Toggling after fail flag: failed, send reset.
// [R5] Resumed polling restarts from first read.
// [R6] Device sets fail flag past pulse limit.
// [R7] Only erase turns zero into one.
// [R8] After fail flag, host issues reset command.
// [R9] Erase window flag low during timeout, then high.
// [R10] Each added sector restarts the timeout.
// [R11] Skip window check only if fast enough.
// [R12] Window high ignores commands; low accepts sectors.
// [R13] Check window before and after each sector.
// [R14] Erase status: poll 0, toggling, window 1.
// [R15] Suspended sector: poll 1, no toggle.
// [R16] Outside suspended sector: plain array data.
// [R17] Poll at programmed or erasing address.
// [R18] Toggle bit inverts on every read.
// [R19] Poll bit complements data until programmed.
// [R20] Single F0 write resets device.
// [R21] Every read is a full enabled cycle.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module flash_host import flash_host_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash pins
	output logic [`FL_ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_dq_out,
	input wire logic [7:0] fl_dq_in,
	output logic fl_dq_oe_n,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n
);

	localparam host_state_t HOST_RESET = '{phase: H_IDLE, recheck: 1'b0, abort_req: 1'b0, first: 8'h00,
		rdata: 8'h00, addr: '0, wdata: 8'h00, ok: 1'b0, fail: 1'b0, closed: 1'b0, rejected: 1'b0,
		cy_start: 1'b0, cy_wr: 1'b0, cy_addr: '0, cy_data: 8'h00, prdata: `RESET_WORD, pready: 1'b0,
		pslverr: 1'b0};

	host_state_t s_reg;
	host_state_t s_next;
	logic cy_done;
	logic [7:0] cy_rdata;
	logic bus_setup;
	logic bus_access;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		unique case (a)
			`OFS_CTRL: reg_sel = 3'h0;
			`OFS_ADDR: reg_sel = 3'h1;
			`OFS_WDATA: reg_sel = 3'h2;
			`OFS_STATUS: reg_sel = 3'h3;
			`OFS_RDATA: reg_sel = 3'h4;
			default: reg_sel = 3'h7;
		endcase
	endfunction

	assign bus_setup = psel & ~penable;
	assign bus_access = psel & penable & s_reg.pready;

	flash_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(s_reg.cy_start),
		.wr(s_reg.cy_wr),
		.addr(s_reg.cy_addr),
		.wdata(s_reg.cy_data),
		.done(cy_done),
		.rdata(cy_rdata),
		.fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out),
		.fl_dq_in(fl_dq_in),
		.fl_dq_oe_n(fl_dq_oe_n),
		.fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.cy_start = 1'b0;

		// The answer is prepared in the setup cycle so pready rises in the first access cycle.
		s_next.pready = bus_setup;
		s_next.pslverr = bus_setup & (reg_sel(paddr) == 3'h7);
		s_next.prdata = `RESET_WORD;
		if (bus_setup && !pwrite) begin
			unique case (reg_sel(paddr))
				3'h1: s_next.prdata[`FL_ADDR_W-1:0] = s_reg.addr;
				3'h2: s_next.prdata[7:0] = s_reg.wdata;
				3'h3: begin
					s_next.prdata[`ST_BUSY_BIT] = (s_reg.phase != H_IDLE);
					s_next.prdata[`ST_OK_BIT] = s_reg.ok;
					s_next.prdata[`ST_FAIL_BIT] = s_reg.fail;
					s_next.prdata[`ST_CLOSED_BIT] = s_reg.closed;
					s_next.prdata[`ST_REJECTED_BIT] = s_reg.rejected;
				end
				3'h4: s_next.prdata[7:0] = s_reg.rdata;
				default: s_next.prdata = `RESET_WORD;
			endcase
		end

		if (bus_access && pwrite) begin
			unique case (reg_sel(paddr))
				3'h0: begin
					if (s_reg.phase != H_IDLE) begin
						s_next.abort_req = pwdata[`CTRL_ABORT_BIT];
					end else begin
						// Every poll begins afresh at its first read, whatever came before.
						s_next.recheck = 1'b0; // [R5]
						s_next.abort_req = 1'b0;
						s_next.ok = 1'b0;
						s_next.fail = 1'b0;
						s_next.closed = 1'b0;
						s_next.rejected = 1'b0;
						s_next.cy_addr = s_reg.addr; // [R17]
						s_next.cy_data = s_reg.wdata;
						unique case (pwdata[`CTRL_CMD_MSB:`CTRL_CMD_LSB])
							`CMD_READ: begin
								s_next.cy_start = 1'b1;
								s_next.cy_wr = 1'b0;
								s_next.phase = H_READ;
							end
							`CMD_WRITE: begin
								s_next.cy_start = 1'b1;
								s_next.cy_wr = 1'b1;
								s_next.phase = H_WRITE;
							end
							`CMD_POLL: begin
								s_next.cy_start = 1'b1;
								s_next.cy_wr = 1'b0;
								s_next.phase = H_POLL_FIRST; // [R1]
							end
							`CMD_RESET: begin
								s_next.cy_start = 1'b1;
								s_next.cy_wr = 1'b1;
								s_next.cy_data = `BYTE_RESET; // [R20]
								s_next.phase = H_RESET;
							end
							`CMD_ERASE_ADD: begin
								// The window is always checked first; no timing guarantee is assumed.
								s_next.cy_start = 1'b1; // [R11]
								s_next.cy_wr = 1'b0;
								s_next.phase = H_ERASE_PRE; // [R13]
							end
							default: s_next.phase = H_IDLE;
						endcase
					end
				end
				3'h1: s_next.addr = pwdata[`FL_ADDR_W-1:0];
				3'h2: s_next.wdata = pwdata[7:0];
				default: s_next.phase = s_next.phase;
			endcase
		end

		if (cy_done) begin
			unique case (s_reg.phase)
				H_READ: begin
					s_next.rdata = cy_rdata; // [R21]
					s_next.ok = 1'b1;
					s_next.phase = H_IDLE;
				end
				H_WRITE: begin
					s_next.ok = 1'b1;
					s_next.phase = H_IDLE;
				end
				H_POLL_FIRST: begin
					s_next.first = cy_rdata; // [R1]
					s_next.rdata = cy_rdata;
					s_next.cy_start = 1'b1;
					s_next.cy_wr = 1'b0;
					s_next.phase = H_POLL_SECOND;
				end
				H_POLL_SECOND: begin
					s_next.rdata = cy_rdata;
					if (s_reg.first[`BIT_TOGGLE] == cy_rdata[`BIT_TOGGLE]) begin
						s_next.ok = 1'b1; // [R1] [R2] [R18]
						s_next.phase = H_IDLE;
					end else if (s_reg.recheck) begin
						// Still toggling after the fail flag: give up and return the part to array reads.
						s_next.fail = 1'b1; // [R4] [R6]
						s_next.cy_start = 1'b1; // [R8]
						s_next.cy_wr = 1'b1;
						s_next.cy_data = `BYTE_RESET; // [R20]
						s_next.phase = H_RESET;
					end else if (s_reg.abort_req) begin
						s_next.abort_req = 1'b0; // [R5]
						s_next.phase = H_IDLE;
					end else begin
						// The toggle may stop just as the fail flag rises, hence one more pair.
						s_next.recheck = cy_rdata[`BIT_FAIL]; // [R3]
						s_next.cy_start = 1'b1;
						s_next.cy_wr = 1'b0;
						s_next.phase = H_POLL_FIRST;
					end
				end
				H_RESET: begin
					s_next.ok = ~s_reg.fail;
					s_next.phase = H_IDLE;
				end
				H_ERASE_PRE: begin
					s_next.rdata = cy_rdata;
					if (cy_rdata[`BIT_WINDOW]) begin
						// Erase has begun and the part would ignore another sector.
						s_next.closed = 1'b1; // [R12] [R13]
						s_next.phase = H_IDLE;
					end else begin
						s_next.cy_start = 1'b1;
						s_next.cy_wr = 1'b1;
						s_next.cy_data = `BYTE_SECTOR_ERASE; // [R10]
						s_next.phase = H_ERASE_WR;
					end
				end
				H_ERASE_WR: begin
					s_next.cy_start = 1'b1;
					s_next.cy_wr = 1'b0;
					s_next.phase = H_ERASE_POST; // [R13]
				end
				H_ERASE_POST: begin
					s_next.rdata = cy_rdata;
					s_next.rejected = cy_rdata[`BIT_WINDOW]; // [R13]
					s_next.ok = ~cy_rdata[`BIT_WINDOW];
					s_next.phase = H_IDLE;
				end
				default: s_next.phase = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= HOST_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;

endmodule

`default_nettype wire

//--- verification/flash_host_chk.sv
// Concurrent checks of the APB answer and flash pin timing of the flash status controller.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module flash_host_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Flash pins
	input wire logic [`FL_ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic [7:0] fl_dq_in,
	input wire logic fl_dq_oe_n,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n
);
	logic [7:0] low_reg;
	logic [7:0] low_next;
	logic mapped;

	// Counts how long chip enable has been low, so cycle lengths are checked exactly.
	assign mapped = paddr inside {`OFS_CTRL, `OFS_ADDR, `OFS_WDATA, `OFS_STATUS, `OFS_RDATA};
	always_comb low_next = fl_ce_n ? 8'h00 : low_reg + 8'h01;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_reg <= 8'h00;
		end else begin
			low_reg <= low_next;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence

	a_apb_answer: assert property (setup_s |=> access_s) else $error("no answer after setup");
	a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable)) else $error("stray ready");
	a_unmapped_err: assert property (pready |-> pslverr == !mapped) else $error("wrong error response");
	a_zero_read: assert property (pready && !pwrite && (!mapped || paddr == `OFS_CTRL) |-> prdata == 32'h0)
		else $error("read data not zero");
	a_read_len: assert property ($rose(fl_ce_n) && $past(!fl_oe_n) |-> low_reg == `RD_CYC)
		else $error("read strobe length wrong");
	a_write_len: assert property ($rose(fl_ce_n) && $past(!fl_we_n) |-> low_reg == `WP_CYC)
		else $error("write pulse length wrong");
	a_read_enables: assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n && fl_dq_oe_n)
		else $error("read without chip enable or with drive");
	a_write_drive: assert property (!fl_we_n |-> !fl_ce_n && !fl_dq_oe_n) else $error("write without data drive");
	a_recovery: assert property ($rose(fl_ce_n) |-> fl_ce_n [*5]) else $error("recovery too short");
	a_pins_hold: assert property (!fl_ce_n && $past(!fl_ce_n) |-> $stable(fl_addr) && $stable(fl_dq_out))
		else $error("address moved in cycle");
endmodule

bind flash_host flash_host_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .fl_dq_oe_n(fl_dq_oe_n),
	.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
`default_nettype wire

//--- verification/flash_dev.sv
// Behavioural model of the parallel flash status bits and erase window.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module flash_dev #(parameter int WIN_NS = 3000) (
	// Flash pins
	input wire logic [`FL_ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	output logic [7:0] fl_dq_in
);
	int left = 0;
	int fail_at = 0;
	int n_acc = 0;
	logic stuck = 1'b0;
	logic armed = 1'b0;
	logic got_f0 = 1'b0;
	logic tog = 1'b0;
	logic fail = 1'b0;
	logic [7:0] q = 8'h00;
	logic [7:0] last = 8'h00;
	logic [`FL_ADDR_W-1:0] wa = '0;
	logic [7:0] wd = 8'h00;
	logic susp = 1'b0;
	logic prog = 1'b0;
	logic [2:0] sec = 3'h0;
	logic [7:0] pdat = 8'h00;
	realtime t_win = 0;

	// A released bus shows the inverse of the last byte, so a stale read cannot pass.
	assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? q : ~last;

	// Suspension freezes the embedded operation, so neither the toggle nor the countdown moves.
	always @(negedge fl_oe_n) begin
		if (susp && fl_addr[16:14] == sec) begin
			q = {1'b1, tog, 6'h00};
		end else if (!susp && (left > 0 || stuck || armed)) begin
			q = {(prog ? ~pdat[7] : 1'b0), tog, fail, 1'b0, armed && ($realtime - t_win >= WIN_NS), 3'b000};
		end else begin
			q = (fl_addr[7:0] ^ 8'h5a) & 8'hd7;
		end
	end

	always @(posedge fl_oe_n) begin
		last = q;
		if (!susp && (left > 0 || stuck || armed)) tog = ~tog;
		if (!susp && left > 0) left--;
		if (stuck && fail_at > 0) fail_at--;
		if (stuck && fail_at == 0) fail = 1'b1;
	end

	always @(posedge fl_we_n) begin
		wa = fl_addr;
		wd = fl_dq_out;
		if (wd == `BYTE_RESET) begin
			{stuck, fail, armed, got_f0} = 4'b0001;
			left = 0;
		end else if (wd == `BYTE_SECTOR_ERASE && !(armed && $realtime - t_win >= WIN_NS)) begin
			armed = 1'b1;
			t_win = $realtime;
			n_acc++;
		end
	end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking testbench of the flash status controller against a flash model.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [`FL_ADDR_W-1:0] fl_addr;
	logic [7:0] fl_dq_out;
	logic [7:0] fl_dq_in;
	logic fl_dq_oe_n;
	logic fl_ce_n;
	logic fl_oe_n;
	logic fl_we_n;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	logic [`FL_ADDR_W-1:0] a;
	logic [7:0] d;

	flash_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
	flash_dev #(.WIN_NS(3000)) u_dev (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in));

	initial forever #2 pclk = ~pclk;

	function automatic logic [31:0] st(input logic ok, input logic fl, input logic cl);
		return {28'h0, cl, fl, ok, 1'b0};
	endfunction

	function automatic logic [31:0] arr(input logic [`FL_ADDR_W-1:0] ad);
		return {24'h0, (ad[7:0] ^ 8'h5a) & 8'hd7};
	endfunction

	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input logic [31:0] cmd);
		apb(1'b1, `OFS_CTRL, cmd);
		do apb(1'b0, `OFS_STATUS, 32'h0); while (rd[`ST_BUSY_BIT] !== 1'b0);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		void'($urandom(32'h2bd937e5));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, `RESET_WORD);
		apb(1'b1, 8'h14, 32'hffffffff);
		chk({31'h0, err}, 32'h1);
		run(32'h7);
		chk(rd, st(0, 0, 0));
		$display("test registers done");
		repeat (4) begin
			a = `FL_ADDR_W'($urandom);
			d = (8'($urandom) & 8'h0f) | 8'h40;
			apb(1'b1, `OFS_ADDR, {15'h0, a});
			apb(1'b1, `OFS_WDATA, {24'h0, d});
			apb(1'b0, `OFS_ADDR, 32'h0);
			chk(rd, {15'h0, a});
			apb(1'b0, `OFS_WDATA, 32'h0);
			chk(rd, {24'h0, d});
			run({29'h0, `CMD_WRITE});
			chk({7'h0, u_dev.wa, u_dev.wd}, {7'h0, a, d});
			run({29'h0, `CMD_READ});
			apb(1'b0, `OFS_RDATA, 32'h0);
			chk(rd, arr(a));
		end
		$display("test single cycles done");
		u_dev.prog = 1'b1;
		u_dev.pdat = d;
		for (int n = 0; n < 9; n++) begin
			u_dev.left = n;
			run({29'h0, `CMD_POLL});
			chk(rd, st(1, 0, 0));
			apb(1'b0, `OFS_RDATA, 32'h0);
			chk(rd, arr(a));
		end
		u_dev.prog = 1'b0;
		u_dev.left = 50;
		u_dev.susp = 1'b1;
		u_dev.sec = a[16:14];
		run({29'h0, `CMD_POLL});
		chk(rd, st(1, 0, 0));
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk(rd & 32'h0000_00bf, 32'h0000_0080);
		u_dev.sec = ~a[16:14];
		run({29'h0, `CMD_POLL});
		chk(rd, st(1, 0, 0));
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk(rd, arr(a));
		u_dev.susp = 1'b0;
		u_dev.left = 0;
		$display("test polling done");
		for (int k = 1; k < 6; k += 2) begin
			u_dev.stuck = 1'b1;
			u_dev.fail_at = k;
			u_dev.got_f0 = 1'b0;
			run({29'h0, `CMD_POLL});
			chk(rd, st(0, 1, 0));
			chk({31'h0, u_dev.got_f0}, 32'h1);
		end
		$display("test failure done");
		u_dev.left = 100000;
		apb(1'b1, `OFS_CTRL, {29'h0, `CMD_POLL});
		repeat (300) @(posedge pclk);
		apb(1'b1, `OFS_CTRL, 32'h8);
		do apb(1'b0, `OFS_STATUS, 32'h0); while (rd[`ST_BUSY_BIT] !== 1'b0);
		chk(rd, st(0, 0, 0));
		u_dev.left = 3;
		run({29'h0, `CMD_POLL});
		chk(rd, st(1, 0, 0));
		$display("test abort and resume done");
		for (int i = 0; i < 3; i++) begin
			run({29'h0, `CMD_ERASE_ADD});
			chk(rd, st(1, 0, 0));
			repeat (500) @(posedge pclk);
		end
		chk(u_dev.n_acc, 3);
		repeat (1000) @(posedge pclk);
		run({29'h0, `CMD_ERASE_ADD});
		chk(rd, st(0, 0, 1));
		u_dev.got_f0 = 1'b0;
		run({29'h0, `CMD_RESET});
		chk({31'h0, u_dev.got_f0}, 32'h1);
		$display("test erase window done");
		u_dev.left = 100000;
		apb(1'b1, `OFS_CTRL, {29'h0, `CMD_POLL});
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({26'h0, pready, pslverr, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n}, 32'h0000_000f);
		presetn <= 1'b1;
		u_dev.left = 0;
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, `RESET_WORD);
		$display("test reset in operation done");
		summarize();
	end
endmodule
`default_nettype wire
